// >>> sample_memory_interface_test.sv
// Self-checking bench: random words written and read back on every bank, strap and size.
// Assumes the checker is bound to the controller from its own file.
`timescale 1ns/1ns
module sample_memory_interface_test
  import smi_pkg::*;
;
  logic              clock_in = 1'b0;
  logic              sys_rst_in = 1'b1;
  logic              kind = 1'b0;
  logic [1:0]        size = 2'h0;
  logic              req_valid = 1'b0;
  logic              req_write = 1'b0;
  logic [1:0]        req_be = 2'h0;
  logic [ADDR_W-1:0] req_addr = 22'h00_0000;
  logic [DATA_W-1:0] req_wdata = 16'h0000;
  logic [DATA_W-1:0] rsp_rdata, rd_in, d_out;
  logic [ADDR_W-1:0] addr_pins, a;
  logic              rsp_valid, oe, we_hi_n, we_lo_n, row_n;
  logic [2:0]        cs_n;
  logic [MUX_W-1:0]  row_cap, col_cap;
  int                fail_count = 0;
  int                check_count = 0;
  int                cycles = 0;
  int                seed = 32'h9544_5f4b;
  // Free running 100 MHz clock.
  always #5 clock_in = ~clock_in;
  smi_mem_ctrl DUT (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .memory_kind_strap_in(kind),
    .dram_size_strap_in(size), .req_valid_in(req_valid), .req_ready_out(),
    .req_addr_in(req_addr), .req_write_in(req_write), .req_byte_en_in(req_be),
    .req_wdata_in(req_wdata), .rsp_valid_out(rsp_valid), .rsp_rdata_out(rsp_rdata),
    .mem_addr_lines_out(addr_pins), .mem_data_lines_in(rd_in), .mem_data_lines_out(d_out),
    .mem_data_lines_oe_out(oe), .upper_byte_write_n_out(we_hi_n),
    .lower_byte_write_n_out(we_lo_n), .row_strobe_n_out(row_n),
    .column_strobe_select_n_out(cs_n));
  smi_memory_model u_mem (.clock_in(clock_in), .mem_addr_lines_in(addr_pins),
    .mem_data_lines_in(d_out), .mem_data_lines_oe_in(oe), .upper_byte_write_n_in(we_hi_n),
    .lower_byte_write_n_in(we_lo_n), .row_strobe_n_in(row_n),
    .column_strobe_select_n_in(cs_n), .mem_data_lines_out(rd_in), .row_cap_out(row_cap),
    .col_cap_out(col_cap));
  // Compare tasks, one for data words and one for address halves and counts.
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_field(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One address half of a dynamic part: width is eight plus the size code.
  function automatic logic [11:0] half(input logic [21:0] ad, input logic [1:0] sz, input logic hi);
    logic [3:0] nb;
    nb = 4'h8 + {2'h0, sz};
    return 12'(((hi ? ad >> nb : ad)) & ((22'h1 << nb) - 22'h1));
  endfunction
  // Entered at a falling edge; returns at the falling edge where the answer is seen.
  task automatic access(input logic wr, input logic [1:0] be, input logic [15:0] wd,
                        output logic [15:0] rd);
    logic [11:0] n;
    req_valid = 1'b1;
    req_addr = a;
    req_write = wr;
    req_be = be;
    req_wdata = wd;
    @(negedge clock_in);
    req_valid = 1'b0;
    n = 12'd0; // Rising edges counted after the take edge.
    while (rsp_valid !== 1'b1 && n < 12'd40)
    begin
      @(negedge clock_in);
      n++;
    end
    check_field(n, 12'(ACCESS_CYC + 6));
    rd = rsp_rdata;
  endtask
  // Full write, byte-masked write, read back; back to back with no idle cycle.
  task automatic run(input logic dyn, input logic [1:0] sz);
    logic [15:0] w1, w2, rd;
    logic [1:0]  be;
    w1 = 16'($random(seed));
    w2 = 16'($random(seed));
    be = 2'($random(seed));
    access(1'b1, 2'h3, w1, rd);
    if (dyn)
    begin
      check_field(col_cap, half(a, sz, 1'b0));
      check_field(row_cap, half(a, sz, 1'b1));
    end
    access(1'b1, be, w2, rd);
    access(1'b0, 2'h0, 16'h0000, rd);
    check_word(rd, {be[1] ? w2[15:8] : w1[15:8], be[0] ? w2[7:0] : w1[7:0]});
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard, far above the roughly 1400 cycles the run needs.
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fail_count++;
      end_sim();
    end
  end
  // Every strap kind and size; straps are flipped after reset, which must change nothing.
  initial
  begin
    for (int k = 0; k < 8; k++)
    begin
      kind = k[2];
      size = k[1:0];
      sys_rst_in = 1'b1;
      repeat (5) @(negedge clock_in);
      sys_rst_in = 1'b0;
      kind = ~kind;
      size = ~size;
      for (int b = 0; b < 4; b++)
      begin
        a = 22'($random(seed));
        a[21:20] = b[1:0];
        run(k[2] && a[21], k[1:0]);
      end
    end
    end_sim();
  end
endmodule

// >>> smi_addr_mux.sv
// Row and column split of a word address for dynamic memories of the four strap sizes.
// Purely combinational; the caller registers what it drives onto the pins.
`timescale 1ns/1ns
module smi_addr_mux
  import smi_pkg::*;
(
  // Address and size.
  input  wire logic [ADDR_W-1:0] word_addr_in,
  input  wire logic [1:0]        size_code_in,
  // Multiplexed halves.
  output logic      [MUX_W-1:0]  row_addr_out,
  output logic      [MUX_W-1:0]  col_addr_out
);

  logic [3:0]       mux_bits;
  logic [MUX_W-1:0] keep_mask;
  logic [ADDR_W-1:0] shifted;

  // Each size adds one row and one column bit.
  assign mux_bits = MUX_BITS_BASE + {2'h0, size_code_in};

  // Keep only the low bits that this size of part decodes.
  for (genvar i = 0; i < MUX_W; i++)
  begin : g_mask
    assign keep_mask[i] = (4'(i) < mux_bits);
  end

  // Column is the low half, row the next half up.
  assign shifted      = word_addr_in >> mux_bits;
  assign col_addr_out = word_addr_in[MUX_W-1:0] & keep_mask;
  assign row_addr_out = shifted[MUX_W-1:0] & keep_mask;

endmodule

// >>> smi_checker_properties.sv
// Assertions on the request and memory pins of the sample memory controller.
// Assumes the straps are held steady while reset is high, as the design latches them there.
`timescale 1ns/1ns
module smi_checker_properties
  import smi_pkg::*;
(
  // Clock, reset and strap.
  input wire logic                clock_in,
  input wire logic                sys_rst_in,
  input wire logic                memory_kind_strap_in,
  // Request side.
  input wire logic                req_valid_in,
  input wire logic                req_ready_out,
  input wire logic [ADDR_W-1:0]   req_addr_in,
  input wire logic                req_write_in,
  input wire logic [1:0]          req_byte_en_in,
  input wire logic [DATA_W-1:0]   req_wdata_in,
  // Memory pins.
  input wire logic [ADDR_W-1:0]   mem_addr_lines_out,
  input wire logic [DATA_W-1:0]   mem_data_lines_out,
  input wire logic                mem_data_lines_oe_out,
  input wire logic                upper_byte_write_n_out,
  input wire logic                lower_byte_write_n_out,
  input wire logic                row_strobe_n_out,
  input wire logic [STROBE_N-1:0] column_strobe_select_n_out
);
  logic kind_q;
  logic take;
  // Own strap copy from reset, so a strap wiggle later must not change the expected cycles.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      kind_q <= memory_kind_strap_in;
  end
  // A request is taken on this edge.
  assign take = req_valid_in && req_ready_out;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  a_static_addr_steady: assert property (
    !column_strobe_select_n_out[0] && !$past(column_strobe_select_n_out[0])
    |-> $stable(mem_addr_lines_out)) else $error("static address moved");
  a_rom_select_refresh: assert property (
    take && !req_addr_in[21] |-> ##1 column_strobe_select_n_out == 3'h7
    ##1 column_strobe_select_n_out == {!kind_q, !kind_q, 1'b0} ##1 row_strobe_n_out == !kind_q)
    else $error("static strobe zero cycle wrong");
  a_optional_static: assert property (
    take && req_addr_in[21] && !kind_q |-> ##2
    column_strobe_select_n_out == ($past(req_addr_in[20], 2) ? 3'h3 : 3'h5)
    ##1 row_strobe_n_out) else $error("optional static strobe wrong");
  a_dynamic_strobe_order: assert property (
    take && req_addr_in[21] && kind_q |-> ##2 (row_strobe_n_out && column_strobe_select_n_out == 3'h7)
    ##1 (!row_strobe_n_out && column_strobe_select_n_out == 3'h7) ##1 (!row_strobe_n_out &&
    column_strobe_select_n_out == ($past(req_addr_in[20], 4) ? 3'h3 : 3'h5)))
    else $error("dynamic strobe order wrong");
  a_refresh_column_first: assert property (
    $fell(row_strobe_n_out) && column_strobe_select_n_out != 3'h7
    |-> $past(column_strobe_select_n_out) != 3'h7) else $error("refresh row before column");
  a_row_released_first: assert property (
    column_strobe_select_n_out == 3'h7 && $past(column_strobe_select_n_out) != 3'h7
    |-> row_strobe_n_out && $past(row_strobe_n_out)) else $error("row released late");
  a_upper_write_enable: assert property (
    take |-> ##2 upper_byte_write_n_out == !($past(req_write_in, 2) && $past(req_byte_en_in[1], 2)))
    else $error("upper write enable wrong");
  a_lower_write_enable: assert property (
    take |-> ##2 lower_byte_write_n_out == !($past(req_write_in, 2) && $past(req_byte_en_in[0], 2)))
    else $error("lower write enable wrong");
  a_write_data_drive: assert property (
    take |=> mem_data_lines_oe_out == $past(req_write_in) &&
    (!mem_data_lines_oe_out || mem_data_lines_out == $past(req_wdata_in)))
    else $error("data bus drive wrong");
endmodule
bind smi_mem_ctrl smi_checker_properties u_checker (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
  .memory_kind_strap_in(memory_kind_strap_in), .req_valid_in(req_valid_in),
  .req_ready_out(req_ready_out), .req_addr_in(req_addr_in), .req_write_in(req_write_in),
  .req_byte_en_in(req_byte_en_in), .req_wdata_in(req_wdata_in),
  .mem_addr_lines_out(mem_addr_lines_out), .mem_data_lines_out(mem_data_lines_out),
  .mem_data_lines_oe_out(mem_data_lines_oe_out), .upper_byte_write_n_out(upper_byte_write_n_out),
  .lower_byte_write_n_out(lower_byte_write_n_out), .row_strobe_n_out(row_strobe_n_out),
  .column_strobe_select_n_out(column_strobe_select_n_out));

// >>> smi_mem_ctrl.sv
// Sample memory interface: runs one static or dynamic access per request on the memory pins.
// Assumes the synthesizer core raises requests synchronous to clock_in and waits for ready.
`timescale 1ns/1ns
module smi_mem_ctrl
  import smi_pkg::*;
(
  // Clock and reset.
  input  wire logic              clock_in,
  input  wire logic              sys_rst_in,
  // Configuration straps.
  input  wire logic              memory_kind_strap_in,
  input  wire logic [1:0]        dram_size_strap_in,
  // Access request from the synthesizer core.
  input  wire logic              req_valid_in,
  output logic                   req_ready_out,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  input  wire logic              req_write_in,
  input  wire logic [1:0]        req_byte_en_in,
  input  wire logic [DATA_W-1:0] req_wdata_in,
  // Access completion.
  output logic                   rsp_valid_out,
  output logic      [DATA_W-1:0] rsp_rdata_out,
  // Memory pins.
  output logic      [ADDR_W-1:0] mem_addr_lines_out,
  input  wire logic [DATA_W-1:0] mem_data_lines_in,
  output logic      [DATA_W-1:0] mem_data_lines_out,
  output logic                   mem_data_lines_oe_out,
  output logic                   upper_byte_write_n_out,
  output logic                   lower_byte_write_n_out,
  output logic                   row_strobe_n_out,
  output logic      [STROBE_N-1:0] column_strobe_select_n_out
);

  smi_state_t          state_q;
  logic                kind_q;
  logic [1:0]          size_q;
  logic                dynamic_q;
  logic                write_q;
  logic [1:0]          byte_en_q;
  logic [ADDR_W-1:0]   addr_q;
  logic [STROBE_N-1:0] sel_q;
  logic [WAIT_W-1:0]   wait_q;
  logic [MUX_W-1:0]    row_addr;
  logic [MUX_W-1:0]    col_addr;
  logic [1:0]          bank_hi;
  logic [STROBE_N-1:0] req_sel;
  logic                req_dynamic;
  logic                accept;

  // Row and column split for the strapped part size.
  smi_addr_mux u_addr_mux (
    .word_addr_in (addr_q),
    .size_code_in (size_q),
    .row_addr_out (row_addr),
    .col_addr_out (col_addr)
  );

  // Straps are sampled while reset is held so a later wiggle cannot reshape the decode.
  // A strap changed in operation therefore has no effect until the next reset.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      kind_q <= memory_kind_strap_in;
      size_q <= dram_size_strap_in;
    end
  end

  // Bank decode: strobe 0 covers the low half of the space, strobes 1 and 2 a quarter each.
  assign bank_hi = req_addr_in[ADDR_W-1:ADDR_W-2];
  always_comb
  begin
    unique case (bank_hi)
      BANK_HI_STROBE1: req_sel = STROBE_SEL1;
      BANK_HI_STROBE2: req_sel = STROBE_SEL2;
      default:         req_sel = STROBE_SEL0;
    endcase
  end
  // Only the optional banks can be dynamic, and only when the kind strap says so.
  // Strobe 0 is never dynamic, so the sample ROM stays reachable whatever the straps say.
  assign req_dynamic = (kind_q == KIND_DYNAMIC) && (req_sel != STROBE_SEL0);

  // A new request is only taken between accesses; no queueing is offered.
  assign req_ready_out = (state_q == SMI_IDLE);
  assign accept        = req_valid_in && req_ready_out;

  // Request latch: holding these for the whole cycle keeps the pins steady.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      addr_q    <= '0;
      write_q   <= 1'b0;
      byte_en_q <= 2'h0;
      sel_q     <= STROBE_SEL0;
      dynamic_q <= 1'b0;
    end
    else if (accept)
    begin
      addr_q    <= req_addr_in;
      write_q   <= req_write_in;
      byte_en_q <= req_byte_en_in;
      sel_q     <= req_sel;
      dynamic_q <= req_dynamic;
    end
  end

  // Sequencer. Both paths visit every state so the pin timing is one table below.
  // Edge 1 after a take: static selects and refresh strobes fall; the dynamic row is driven.
  // Edge 2: the row strobe falls for refresh or to latch the row; the column is driven.
  // Edge 3: the selected dynamic column strobe falls.
  // Edges 4 to 10: data phase, paced by the access timer.
  // Edge 11: read data is sampled and the row strobe rises.
  // Edge 12: column strobes and write enables rise.
  // Edge 13: the data drivers turn off and the completion pulse is raised.
  // Write enables fall at edge 1 on both paths, with the static selects and ahead of the row and dynamic column strobes.
  // The fixed length wastes a few cycles on static parts, but one schedule is easier to check.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= SMI_IDLE;
    end
    else
    begin
      unique case (state_q)
        SMI_IDLE:    if (accept) state_q <= SMI_SETUP;
        SMI_SETUP:   state_q <= SMI_FIRST;
        SMI_FIRST:   state_q <= SMI_SECOND;
        SMI_SECOND:  state_q <= SMI_STROBE;
        SMI_STROBE:  state_q <= SMI_DATA;
        SMI_DATA:    if (wait_q == ACCESS_LAST) state_q <= SMI_RELEASE;
        SMI_RELEASE: state_q <= SMI_END;
        SMI_END:     state_q <= SMI_IDLE;
      endcase
    end
  end

  // Access time counter, running only while data is awaited.
  // Clearing it outside the data phase means a reset mid-access leaves no stale count.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in || state_q != SMI_DATA)
    begin
      wait_q <= '0;
    end
    else
    begin
      wait_q <= wait_q + 1'b1;
    end
  end

  // Address lines. Static: full address from setup to end. Dynamic: row, then column.
  // The column replaces the row on the edge where the row strobe falls, so parts that need
  // a row hold time above zero would need a slower schedule.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      mem_addr_lines_out <= '0;
    end
    else if (accept)
    begin
      mem_addr_lines_out <= req_addr_in;
    end
    else if (dynamic_q && state_q == SMI_SETUP)
    begin
      mem_addr_lines_out <= {{(ADDR_W-MUX_W){1'b0}}, row_addr};
    end
    else if (dynamic_q && state_q == SMI_FIRST)
    begin
      mem_addr_lines_out <= {{(ADDR_W-MUX_W){1'b0}}, col_addr};
    end
  end

  // Row strobe. Dynamic: low the cycle after the row address lands. Static with refresh:
  // low one cycle after the column strobes, and raised one cycle before them.
  // Holding the row address a full cycle before the strobe gives the parts their setup time.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      row_strobe_n_out <= 1'b1;
    end
    else if (dynamic_q && state_q == SMI_FIRST)
    begin
      row_strobe_n_out <= 1'b0;
    end
    else if (!dynamic_q && kind_q == KIND_DYNAMIC && state_q == SMI_FIRST)
    begin
      row_strobe_n_out <= 1'b0;
    end
    else if (state_q == SMI_DATA && wait_q == ACCESS_LAST)
    begin
      row_strobe_n_out <= 1'b1;
    end
  end

  // Column strobes. Static: chip select plus the refresh strobes one cycle after the address.
  // Dynamic: only the selected strobe, once the column address has settled.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      column_strobe_select_n_out <= STROBE_IDLE_N;
    end
    else if (!dynamic_q && state_q == SMI_SETUP)
    begin
      if (kind_q == KIND_DYNAMIC)
      begin
        column_strobe_select_n_out <= ~(sel_q | STROBE_OPTIONAL);
      end
      else
      begin
        column_strobe_select_n_out <= ~sel_q;
      end
    end
    else if (dynamic_q && state_q == SMI_SECOND)
    begin
      column_strobe_select_n_out <= ~sel_q;
    end
    else if (state_q == SMI_RELEASE)
    begin
      column_strobe_select_n_out <= STROBE_IDLE_N;
    end
  end

  // Byte write enables: set in setup, falling with the static selects and before any row or dynamic column strobe.
  // For dynamic parts this gives an early write, so the data pins never turn around mid-cycle.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in || state_q == SMI_RELEASE)
    begin
      upper_byte_write_n_out <= 1'b1;
      lower_byte_write_n_out <= 1'b1;
    end
    else if (state_q == SMI_SETUP && write_q)
    begin
      upper_byte_write_n_out <= ~byte_en_q[1];
      lower_byte_write_n_out <= ~byte_en_q[0];
    end
  end

  // Write data is driven from setup through end; the pins float otherwise.
  // The bus turns around only after the strobes are idle, so no part fights the drivers.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      mem_data_lines_out    <= '0;
      mem_data_lines_oe_out <= 1'b0;
    end
    else if (accept)
    begin
      mem_data_lines_out    <= req_wdata_in;
      mem_data_lines_oe_out <= req_write_in;
    end
    else if (state_q == SMI_END)
    begin
      mem_data_lines_oe_out <= 1'b0;
    end
  end

  // Read data is sampled on the last access cycle, while the strobes of the access are still low.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      rsp_rdata_out <= '0;
    end
    else if (state_q == SMI_DATA && wait_q == ACCESS_LAST && !write_q)
    begin
      rsp_rdata_out <= mem_data_lines_in;
    end
  end

  // Completion pulse once all strobes are back high.
  // Registered, so the core sees it only after the memory pins are idle again.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      rsp_valid_out <= 1'b0;
    end
    else
    begin
      rsp_valid_out <= (state_q == SMI_END);
    end
  end

endmodule

// >>> smi_memory_model.sv
// Behavioural sample memory: static parts keyed by full address, dynamic parts by row and column.
// Assumes the controller's pins change only on the rising clock edge.
`timescale 1ns/1ns
module smi_memory_model
  import smi_pkg::*;
(
  // Clock and controller pins.
  input  wire logic                clock_in,
  input  wire logic [ADDR_W-1:0]   mem_addr_lines_in,
  input  wire logic [DATA_W-1:0]   mem_data_lines_in,
  input  wire logic                mem_data_lines_oe_in,
  input  wire logic                upper_byte_write_n_in,
  input  wire logic                lower_byte_write_n_in,
  input  wire logic                row_strobe_n_in,
  input  wire logic [STROBE_N-1:0] column_strobe_select_n_in,
  // Read data, the last dynamic row half and the low address half at the last column strobe.
  output logic      [DATA_W-1:0]   mem_data_lines_out,
  output logic      [MUX_W-1:0]    row_cap_out,
  output logic      [MUX_W-1:0]    col_cap_out
);
  logic [DATA_W-1:0] store [logic [24:0]];
  logic [24:0]       key_q;
  logic [2:0]        cs_q = 3'h7;
  logic              row_q = 1'b1;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] last_q = 16'h0000;
  logic              active;
  // Halves are taken from the address held before each strobe fell, a part with no hold time.
  always @(posedge clock_in)
  begin
    cs_q <= column_strobe_select_n_in;
    row_q <= row_strobe_n_in;
    addr_q <= mem_addr_lines_in;
    last_q <= mem_data_lines_out;
    if (!row_strobe_n_in && row_q && column_strobe_select_n_in == 3'h7)
      row_cap_out <= addr_q[11:0];
    if (column_strobe_select_n_in != 3'h7 && cs_q == 3'h7)
    begin
      col_cap_out <= addr_q[11:0];
      key_q <= row_strobe_n_in ? {3'h4, addr_q} : {1'b0, row_cap_out, addr_q[11:0]};
    end
    if (active && !upper_byte_write_n_in)
      store[key_q][15:8] <= mem_data_lines_in[15:8];
    if (active && !lower_byte_write_n_in)
      store[key_q][7:0] <= mem_data_lines_in[7:0];
  end
  // Outside a read the bus shows a changing pattern, since nothing holds it.
  assign active = column_strobe_select_n_in != 3'h7 && cs_q != 3'h7;
  always @*
  begin
    if (active && !mem_data_lines_oe_in && store.exists(key_q))
      mem_data_lines_out = store[key_q];
    else
      mem_data_lines_out = ~last_q;
  end
endmodule

// >>> smi_pkg.sv
// Constants shared by the sample memory interface: widths, bank decode, strap codes, timing.
// Assumes a 100 MHz system clock; the cycle counts below are derived from that rate.
package smi_pkg;

  // Bus widths.
  localparam int unsigned ADDR_W   = 22;  // Word address lines, line 1 through line 22.
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned MUX_W    = 12;  // Low lines that carry the multiplexed dynamic address.
  localparam int unsigned STROBE_N = 3;

  // Strobe 0 always holds the static sample ROM; strobes 1 and 2 hold the optional memories.
  localparam logic [1:0] BANK_HI_STROBE1 = 2'h2;  // Top two address bits selecting strobe 1.
  localparam logic [1:0] BANK_HI_STROBE2 = 2'h3;  // Top two address bits selecting strobe 2.
  localparam logic [2:0] STROBE_SEL0     = 3'h1;
  localparam logic [2:0] STROBE_SEL1     = 3'h2;
  localparam logic [2:0] STROBE_SEL2     = 3'h4;
  localparam logic [2:0] STROBE_OPTIONAL = 3'h6;  // Strobes used for refresh of dynamic parts.
  localparam logic [2:0] STROBE_IDLE_N   = 3'h7;

  // Memory kind strap and dynamic size strap codes.
  localparam logic       KIND_STATIC  = 1'h0;
  localparam logic       KIND_DYNAMIC = 1'h1;
  localparam logic [1:0] SIZE_64K     = 2'h0;
  localparam logic [1:0] SIZE_256K    = 2'h1;
  localparam logic [1:0] SIZE_1M      = 2'h2;
  localparam logic [1:0] SIZE_4M      = 2'h3;
  // Row and column width is this base plus the size code: 8, 9, 10 or 11 bits.
  localparam logic [3:0] MUX_BITS_BASE = 4'h8;

  // Timing: the strobe to data time that the attached parts need.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ACCESS_NS     = 70;
  localparam int unsigned ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAIT_W        = 4;
  localparam logic [WAIT_W-1:0] ACCESS_LAST = WAIT_W'(ACCESS_CYC - 1);

  // Cycle sequencer, Gray coded along both the static and the dynamic path.
  typedef enum logic [2:0] {
    SMI_IDLE    = 3'h0,
    SMI_SETUP   = 3'h1,
    SMI_FIRST   = 3'h3,
    SMI_SECOND  = 3'h2,
    SMI_STROBE  = 3'h6,
    SMI_DATA    = 3'h7,
    SMI_RELEASE = 3'h5,
    SMI_END     = 3'h4
  } smi_state_t;

endpackage
